//--- hw/cmbf_defines.svh
//----------------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------------
// Summary of operation
// RULE1: buffers sit in plain RAM; engine moves messages by memory access
// RULE2: software picks buffer base and size and writes message words directly
// RULE3: word 0 bits 12..2 hold standard identifier MSB first; 15..13 zero
// RULE4: word 0 bit 1 is substitute remote flag for standard frames
// RULE5: software writes substitute remote flag as one for extended frames
// RULE6: word 0 bit 0 selects extended (1) or standard (0) identifier
// RULE7: word 1 bits 11..0 hold extended identifier 17..6; 15..12 zero
// RULE8: word 2 bits 15..10 hold extended identifier 5..0
// RULE9: word 2 bit 9 is the remote request flag for extended frames
// RULE10: remote flag of word 2 is ignored for standard frames
// RULE11: software writes reserved bits 8 and 4 of word 2 as zero
// RULE12: word 2 bits 3..0 hold length code; bits 7..5 zero
// RULE13: words 3..6 hold payload bytes, even byte low, odd byte high
// RULE14: on receive, word 7 bits 12..8 get the matching filter number
// RULE15: filter field written only for receive buffers, not for transmit
// RULE16: word 7 low byte and bits 15..13 always zero
// RULE17: all buffer words sit in memory reached by the memory master port
// RULE18: buffer n spans eight 16-bit words from base plus 16*n bytes
`ifndef CMBF_DEFINES_SVH
`define CMBF_DEFINES_SVH

`define CMBF_WORDS_PER_BUF   8
`define CMBF_BYTES_PER_WORD  2
`define CMBF_TX_LAST_WORD    3'h6
`define CMBF_STD_MSB         12
`define CMBF_STD_LSB         2
`define CMBF_SRR_BIT         1
`define CMBF_IDE_BIT         0
`define CMBF_EXTH_MSB        11
`define CMBF_EXTL_MSB        15
`define CMBF_EXTL_LSB        10
`define CMBF_RTR_BIT         9
`define CMBF_RSVH_BIT        8
`define CMBF_RSVL_BIT        4
`define CMBF_DLC_MSB         3
`define CMBF_FILT_MSB        12
`define CMBF_FILT_LSB        8
`define CMBF_RST_WORD        16'h0000

`endif

//--- hw/cmbf_pkg.sv
package cmbf_pkg;

  typedef enum logic [2:0] {
    CMBF_IDLE,
    CMBF_STORE,
    CMBF_FETCH_ISSUE,
    CMBF_FETCH_WAIT
  } cmbf_mode_type;

  typedef logic [15:0] cmbf_word_type;
  typedef logic [2:0]  cmbf_widx_type;

endpackage

//--- hw/cmbf_fifo.sv
`timescale 1ns/1ps
module cmbf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             MCLK,
  input  wire logic             RST,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  input  wire logic [WIDTH-1:0] IN_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY,
  output logic      [WIDTH-1:0] OUT_DATA,
  output logic                  EMPTY
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
      $error("cmbf_fifo: depth must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
  } cmbf_fifo_state_type;

  cmbf_fifo_state_type fifo_ff;
  cmbf_fifo_state_type nxt_fifo_ff;
  logic                push;
  logic                pop;

  assign IN_READY  = (fifo_ff.count != (PW+1)'(DEPTH));
  assign OUT_VALID = (fifo_ff.count != '0);
  assign EMPTY     = ~OUT_VALID;
  assign OUT_DATA  = fifo_ff.mem[fifo_ff.rd_ptr];
  assign push      = IN_VALID & IN_READY;
  assign pop       = OUT_VALID & OUT_READY;

  always_comb begin
    nxt_fifo_ff = fifo_ff;
    if (push) begin
      nxt_fifo_ff.mem[fifo_ff.wr_ptr] = IN_DATA;
      nxt_fifo_ff.wr_ptr = fifo_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_fifo_ff.rd_ptr = fifo_ff.rd_ptr + 1'b1;
    end
    nxt_fifo_ff.count = fifo_ff.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      fifo_ff <= '0;
    end else begin
      fifo_ff <= nxt_fifo_ff;
    end
  end
endmodule // cmbf_fifo

//--- hw/cmbf_word_pack.sv
`timescale 1ns/1ps
`include "cmbf_defines.svh"
module cmbf_word_pack (
  input  wire logic [10:0]          STD_IDENT,
  input  wire logic [17:0]          EXT_IDENT,
  input  wire logic                 EXTENDED,
  input  wire logic                 REMOTE,
  input  wire logic [3:0]           DLC,
  input  wire logic [63:0]          DATA,
  input  wire logic [4:0]           FILTER,
  input  wire cmbf_pkg::cmbf_widx_type WORD_IDX,
  output cmbf_pkg::cmbf_word_type   WORD
);
  import cmbf_pkg::*;

  always_comb begin
    WORD = `CMBF_RST_WORD;                                      // [RULE16]
    unique case (WORD_IDX)
      3'h0: begin
        WORD[`CMBF_STD_MSB:`CMBF_STD_LSB] = STD_IDENT;          // [RULE3]
        // extended frames must carry a set substitute flag
        WORD[`CMBF_SRR_BIT] = EXTENDED | REMOTE;                // [RULE4]
        WORD[`CMBF_IDE_BIT] = EXTENDED;                         // [RULE6]
      end
      3'h1: WORD[`CMBF_EXTH_MSB:0] = EXT_IDENT[17:6];           // [RULE7]
      3'h2: begin
        WORD[`CMBF_EXTL_MSB:`CMBF_EXTL_LSB] = EXT_IDENT[5:0];   // [RULE8]
        WORD[`CMBF_RTR_BIT] = EXTENDED & REMOTE;                // [RULE9]
        WORD[`CMBF_DLC_MSB:0] = DLC;                            // [RULE12]
      end
      3'h3: WORD = DATA[15:0];                                  // [RULE13]
      3'h4: WORD = DATA[31:16];                                 // [RULE13]
      3'h5: WORD = DATA[47:32];                                 // [RULE13]
      3'h6: WORD = DATA[63:48];                                 // [RULE13]
      // unused bits of word 7 keep the cleared default
      3'h7: WORD[`CMBF_FILT_MSB:`CMBF_FILT_LSB] = FILTER;  // [RULE14]
    endcase
  end
endmodule // cmbf_word_pack

//--- hw/cmbf_top.sv
`timescale 1ns/1ps
`include "cmbf_defines.svh"
module cmbf_top #(
  parameter int ADDR_W     = 16,
  parameter int BUF_W      = 5,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic              MCLK,
  input  wire logic              RST,
  // buffer area placement, owned by software
  input  wire logic [ADDR_W-1:0] BASE_ADDR,
  // store side: received message from the protocol engine
  input  wire logic              RX_VALID,
  output logic                   RX_READY,
  input  wire logic [BUF_W-1:0]  RX_BUFFER,
  input  wire logic [10:0]       RX_STD_IDENT,
  input  wire logic [17:0]       RX_EXT_IDENT,
  input  wire logic              RX_EXTENDED,
  input  wire logic              RX_REMOTE,
  input  wire logic [3:0]        RX_DLC,
  input  wire logic [63:0]       RX_DATA,
  input  wire logic [4:0]        RX_FILTER,
  // fetch side: message to transmit
  input  wire logic              TX_REQ,
  output logic                   TX_REQ_READY,
  input  wire logic [BUF_W-1:0]  TX_BUFFER,
  output logic                   TX_DONE,
  output logic [10:0]            TX_STD_IDENT,
  output logic [17:0]            TX_EXT_IDENT,
  output logic                   TX_EXTENDED,
  output logic                   TX_REMOTE,
  output logic [3:0]             TX_DLC,
  output logic [63:0]            TX_DATA,
  // memory master port, 16-bit words
  output logic                   MEM_REQ,
  output logic                   MEM_WE,
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic [15:0]            MEM_WDATA,
  input  wire logic              MEM_GNT,
  input  wire logic              MEM_RVALID,
  input  wire logic [15:0]       MEM_RDATA
);
  import cmbf_pkg::*;

  localparam int FW = ADDR_W + 16;

  initial begin
    if (ADDR_W < BUF_W + 4 || BUF_W < 1 || FIFO_DEPTH < 2)
      $error("cmbf_top: address too narrow for buffer count");
  end

  //--------------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------------
  typedef struct packed {
    cmbf_mode_type     mode;
    cmbf_widx_type     widx;
    logic [BUF_W-1:0]  buf_num;
    logic [10:0]       std_ident;
    logic [17:0]       ext_ident;
    logic              extended;
    logic              remote;
    logic [3:0]        dlc;
    logic [63:0]       data;
    logic [4:0]        filter;
    logic [10:0]       tx_std;
    logic [17:0]       tx_ext;
    logic              tx_extended;
    logic              tx_remote;
    logic [3:0]        tx_dlc;
    logic [63:0]       tx_data;
    logic              tx_done;
  } cmbf_top_state_type;

  cmbf_top_state_type state_ff;
  cmbf_top_state_type nxt_state_ff;

  cmbf_word_type     pack_word;
  logic [ADDR_W-1:0] word_addr;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [FW-1:0]     fifo_out_data;
  logic              fifo_empty;
  logic              fetching;

  //--------------------------------------------------------------------------
  // word layout and address
  //--------------------------------------------------------------------------
  cmbf_word_pack u_pack (
    .STD_IDENT (state_ff.std_ident),
    .EXT_IDENT (state_ff.ext_ident),
    .EXTENDED  (state_ff.extended),
    .REMOTE    (state_ff.remote),
    .DLC       (state_ff.dlc),
    .DATA      (state_ff.data),
    .FILTER    (state_ff.filter),
    .WORD_IDX  (state_ff.widx),
    .WORD      (pack_word)
  );

  // eight consecutive words per buffer, word 0 lowest
  assign word_addr = BASE_ADDR                                     // [RULE2]
    + ADDR_W'(({state_ff.buf_num, state_ff.widx})
              * `CMBF_BYTES_PER_WORD);                              // [RULE18]

  //--------------------------------------------------------------------------
  // write buffer between formatter and memory
  //--------------------------------------------------------------------------
  // the fifo decouples a whole 8-word store from memory stalls; the
  // formatter itself waits when it fills
  assign fifo_in_valid = (state_ff.mode == CMBF_STORE);

  cmbf_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .MCLK      (MCLK),
    .RST       (RST),
    .IN_VALID  (fifo_in_valid),
    .IN_READY  (fifo_in_ready),
    .IN_DATA   ({word_addr, pack_word}),
    .OUT_VALID (fifo_out_valid),
    .OUT_READY (fifo_out_ready),
    .OUT_DATA  (fifo_out_data),
    .EMPTY     (fifo_empty)
  );

  //--------------------------------------------------------------------------
  // memory port
  //--------------------------------------------------------------------------
  assign fetching       = (state_ff.mode == CMBF_FETCH_ISSUE)
                        | (state_ff.mode == CMBF_FETCH_WAIT);
  // a fetch only starts with the fifo drained, so reads never pass writes
  assign fifo_out_ready = MEM_GNT & ~fetching;                      // [RULE1]
  assign MEM_REQ        = fetching ? (state_ff.mode == CMBF_FETCH_ISSUE)
                                   : fifo_out_valid;                // [RULE17]
  assign MEM_WE         = ~fetching & fifo_out_valid;
  assign MEM_ADDR       = fetching ? word_addr
                                   : fifo_out_data[FW-1:16];
  assign MEM_WDATA      = fetching ? 16'h0000 : fifo_out_data[15:0];

  //--------------------------------------------------------------------------
  // engine handshakes
  //--------------------------------------------------------------------------
  assign RX_READY     = (state_ff.mode == CMBF_IDLE);
  // stores win over fetches; a fetch waits for pending writes to land
  assign TX_REQ_READY = (state_ff.mode == CMBF_IDLE) & ~RX_VALID
                      & fifo_empty;

  assign TX_DONE      = state_ff.tx_done;
  assign TX_STD_IDENT = state_ff.tx_std;
  assign TX_EXT_IDENT = state_ff.tx_ext;
  assign TX_EXTENDED  = state_ff.tx_extended;
  assign TX_REMOTE    = state_ff.tx_remote;
  assign TX_DLC       = state_ff.tx_dlc;
  assign TX_DATA      = state_ff.tx_data;

  //--------------------------------------------------------------------------
  // sequencing
  //--------------------------------------------------------------------------
  always_comb begin
    nxt_state_ff         = state_ff;
    nxt_state_ff.tx_done = 1'b0;
    unique case (state_ff.mode)
      CMBF_IDLE: begin
        if (RX_VALID) begin
          nxt_state_ff.mode      = CMBF_STORE;
          nxt_state_ff.widx      = 3'h0;
          nxt_state_ff.buf_num   = RX_BUFFER;
          nxt_state_ff.std_ident = RX_STD_IDENT;
          nxt_state_ff.ext_ident = RX_EXT_IDENT;
          nxt_state_ff.extended  = RX_EXTENDED;
          nxt_state_ff.remote    = RX_REMOTE;
          nxt_state_ff.dlc       = RX_DLC;
          nxt_state_ff.data      = RX_DATA;
          nxt_state_ff.filter    = RX_FILTER;                        // [RULE14]
        end else if (TX_REQ && fifo_empty) begin
          nxt_state_ff.mode    = CMBF_FETCH_ISSUE;
          nxt_state_ff.widx    = 3'h0;
          nxt_state_ff.buf_num = TX_BUFFER;
        end
      end
      CMBF_STORE: begin
        if (fifo_in_ready) begin
          // all eight words, filter word last, only on receive
          if (state_ff.widx == 3'h7) begin                          // [RULE15]
            nxt_state_ff.mode = CMBF_IDLE;
          end
          nxt_state_ff.widx = state_ff.widx + 3'h1;
        end
      end
      CMBF_FETCH_ISSUE: begin
        if (MEM_GNT) begin
          nxt_state_ff.mode = CMBF_FETCH_WAIT;
        end
      end
      CMBF_FETCH_WAIT: begin
        if (MEM_RVALID) begin
          unique case (state_ff.widx)
            3'h0: begin
              nxt_state_ff.tx_std =
                MEM_RDATA[`CMBF_STD_MSB:`CMBF_STD_LSB];             // [RULE3]
              nxt_state_ff.tx_extended = MEM_RDATA[`CMBF_IDE_BIT];   // [RULE6]
              nxt_state_ff.tx_remote   = MEM_RDATA[`CMBF_SRR_BIT];   // [RULE4]
            end
            3'h1: nxt_state_ff.tx_ext[17:6] =
                    MEM_RDATA[`CMBF_EXTH_MSB:0];                     // [RULE7]
            3'h2: begin
              nxt_state_ff.tx_ext[5:0] =
                MEM_RDATA[`CMBF_EXTL_MSB:`CMBF_EXTL_LSB];           // [RULE8]
              // standard frames keep the substitute flag from word 0
              if (state_ff.tx_extended) begin                       // [RULE10]
                nxt_state_ff.tx_remote = MEM_RDATA[`CMBF_RTR_BIT];   // [RULE9]
              end
              nxt_state_ff.tx_dlc = MEM_RDATA[`CMBF_DLC_MSB:0];     // [RULE12]
            end
            3'h3: nxt_state_ff.tx_data[15:0]  = MEM_RDATA;          // [RULE13]
            3'h4: nxt_state_ff.tx_data[31:16] = MEM_RDATA;          // [RULE13]
            3'h5: nxt_state_ff.tx_data[47:32] = MEM_RDATA;          // [RULE13]
            default: nxt_state_ff.tx_data[63:48] = MEM_RDATA;       // [RULE13]
          endcase
          // transmit fetch stops at word 6: filter word is not used
          if (state_ff.widx == `CMBF_TX_LAST_WORD) begin            // [RULE15]
            nxt_state_ff.mode    = CMBF_IDLE;
            nxt_state_ff.tx_done = 1'b1;
          end else begin
            nxt_state_ff.mode = CMBF_FETCH_ISSUE;
            nxt_state_ff.widx = state_ff.widx + 3'h1;
          end
        end
      end
      default: nxt_state_ff.mode = CMBF_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_ff      <= '0;
      state_ff.mode <= CMBF_IDLE;
    end else begin
      state_ff <= nxt_state_ff;
    end
  end
endmodule // cmbf_top

//--- sim/cmbf_properties.sv
`timescale 1ns/1ps
module cmbf_properties #(
  parameter int ADDR_W = 16
) (
  input wire logic              MCLK,
  input wire logic              RST,
  input wire logic [ADDR_W-1:0] BASE_ADDR,
  input wire logic              RX_VALID,
  input wire logic              RX_READY,
  input wire logic              TX_REQ_READY,
  input wire logic              TX_DONE,
  input wire logic              MEM_REQ,
  input wire logic              MEM_WE,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic [15:0]       MEM_WDATA,
  input wire logic              MEM_GNT,
  input wire logic              MEM_RVALID
);
  logic [ADDR_W-1:0] off;
  logic [2:0]        wi;
  logic              wr;
  // word index is taken from the offset to the base, so any base works
  assign off = MEM_ADDR - BASE_ADDR;
  assign wi  = off[3:1];
  assign wr  = MEM_REQ && MEM_WE;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  req_hold_a: assert property (
    MEM_REQ && !MEM_GNT |=> MEM_REQ && $stable({MEM_WE, MEM_ADDR, MEM_WDATA}))
    else $error("memory request changed before grant");
  word0_fmt_a: assert property (
    wr && wi == 3'h0 |-> MEM_WDATA[15:13] == 3'h0
      && (!MEM_WDATA[0] || MEM_WDATA[1]))
    else $error("word 0 format wrong");
  word1_fmt_a: assert property (
    wr && wi == 3'h1 |-> MEM_WDATA[15:12] == 4'h0)
    else $error("word 1 upper bits not zero");
  word2_fmt_a: assert property (
    wr && wi == 3'h2 |-> MEM_WDATA[8:4] == 5'h00)
    else $error("word 2 reserved bits not zero");
  word7_fmt_a: assert property (
    wr && wi == 3'h7 |-> MEM_WDATA[15:13] == 3'h0 && MEM_WDATA[7:0] == 8'h00)
    else $error("word 7 unused bits not zero");
  no_read_w7_a: assert property (
    MEM_REQ && !MEM_WE |-> wi != 3'h7)
    else $error("fetch read word 7");
  done_pulse_a: assert property (
    TX_DONE |-> $past(MEM_RVALID) ##1 !TX_DONE)
    else $error("fetch done pulse misplaced");
  store_busy_a: assert property (
    RX_VALID && RX_READY |=> !RX_READY [*4])
    else $error("store accepted while busy");
  store_write_a: assert property (
    RX_VALID && RX_READY |-> ##[2:60] wr)
    else $error("store produced no memory write");
  fetch_idle_a: assert property (
    TX_REQ_READY |-> !RX_VALID && !MEM_REQ)
    else $error("fetch offered while busy");
  store_c: cover property (RX_VALID && RX_READY);
  fetch_c: cover property (TX_DONE);
  stall_c: cover property (MEM_REQ && !MEM_GNT ##1 MEM_GNT);
endmodule // cmbf_properties

bind cmbf_top cmbf_properties #(.ADDR_W(ADDR_W)) cmbf_properties_inst (
  .MCLK         (MCLK),
  .RST          (RST),
  .BASE_ADDR    (BASE_ADDR),
  .RX_VALID     (RX_VALID),
  .RX_READY     (RX_READY),
  .TX_REQ_READY (TX_REQ_READY),
  .TX_DONE      (TX_DONE),
  .MEM_REQ      (MEM_REQ),
  .MEM_WE       (MEM_WE),
  .MEM_ADDR     (MEM_ADDR),
  .MEM_WDATA    (MEM_WDATA),
  .MEM_GNT      (MEM_GNT),
  .MEM_RVALID   (MEM_RVALID)
);

//--- sim/cmbf_mem_model.sv
`timescale 1ns/1ps
module cmbf_mem_model (
  input  wire logic        MCLK,
  input  wire logic        SLOW,
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WE,
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic [15:0] MEM_WDATA,
  output logic             MEM_GNT,
  output logic             MEM_RVALID,
  output logic [15:0]      MEM_RDATA
);
  logic [15:0] mem [0:32767];
  logic        tog_ff = 1'b0;
  logic [15:0] rd_ff  = 16'h0000;
  logic        rv_ff  = 1'b0;
  assign MEM_RVALID = rv_ff;
  // slow mode grants every other cycle so requests must stand
  assign MEM_GNT   = MEM_REQ && (!SLOW || tog_ff);
  // outside a valid beat the data bus shows the inverse of the last word
  assign MEM_RDATA = MEM_RVALID ? rd_ff : ~rd_ff;
  always @(posedge MCLK) begin
    tog_ff     <= ~tog_ff;
    rv_ff      <= MEM_GNT && !MEM_WE;
    if (MEM_GNT && MEM_WE) begin
      mem[MEM_ADDR[15:1]] <= MEM_WDATA;
    end
    if (MEM_GNT && !MEM_WE) begin
      rd_ff <= mem[MEM_ADDR[15:1]];
    end
  end
endmodule // cmbf_mem_model

//--- sim/cmbf_tb.sv
`timescale 1ns/1ps
module tb_top;
  logic MCLK = 1'b0, RST = 1'b1, SLOW = 1'b0;
  logic RX_VALID = 1'b0, TX_REQ = 1'b0, RX_EXTENDED = 1'b0, RX_REMOTE = 1'b0;
  logic [15:0] BASE_ADDR = 16'h1000;
  logic [4:0]  RX_BUFFER = 5'h00, TX_BUFFER = 5'h00, RX_FILTER = 5'h00;
  logic [10:0] RX_STD_IDENT = 11'h000;
  logic [17:0] RX_EXT_IDENT = 18'h00000;
  logic [3:0]  RX_DLC = 4'h0;
  logic [63:0] RX_DATA = 64'h0;
  logic RX_READY, TX_REQ_READY, TX_DONE, TX_EXTENDED, TX_REMOTE;
  logic [10:0] TX_STD_IDENT;
  logic [17:0] TX_EXT_IDENT;
  logic [3:0]  TX_DLC;
  logic [63:0] TX_DATA;
  logic MEM_REQ, MEM_WE, MEM_GNT, MEM_RVALID;
  logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA;
  int n_mismatch = 0;
  int checks_done = 0;

  always #20 MCLK = ~MCLK;

  cmbf_top #(.ADDR_W(16), .BUF_W(5), .FIFO_DEPTH(8)) cmbf_top_inst (
    .MCLK         (MCLK),
    .RST          (RST),
    .BASE_ADDR    (BASE_ADDR),
    .RX_VALID     (RX_VALID),
    .RX_READY     (RX_READY),
    .RX_BUFFER    (RX_BUFFER),
    .RX_STD_IDENT (RX_STD_IDENT),
    .RX_EXT_IDENT (RX_EXT_IDENT),
    .RX_EXTENDED  (RX_EXTENDED),
    .RX_REMOTE    (RX_REMOTE),
    .RX_DLC       (RX_DLC),
    .RX_DATA      (RX_DATA),
    .RX_FILTER    (RX_FILTER),
    .TX_REQ       (TX_REQ),
    .TX_REQ_READY (TX_REQ_READY),
    .TX_BUFFER    (TX_BUFFER),
    .TX_DONE      (TX_DONE),
    .TX_STD_IDENT (TX_STD_IDENT),
    .TX_EXT_IDENT (TX_EXT_IDENT),
    .TX_EXTENDED  (TX_EXTENDED),
    .TX_REMOTE    (TX_REMOTE),
    .TX_DLC       (TX_DLC),
    .TX_DATA      (TX_DATA),
    .MEM_REQ      (MEM_REQ),
    .MEM_WE       (MEM_WE),
    .MEM_ADDR     (MEM_ADDR),
    .MEM_WDATA    (MEM_WDATA),
    .MEM_GNT      (MEM_GNT),
    .MEM_RVALID   (MEM_RVALID),
    .MEM_RDATA    (MEM_RDATA)
  );
  cmbf_mem_model cmbf_mem_model_inst (
    .MCLK       (MCLK),
    .SLOW       (SLOW),
    .MEM_REQ    (MEM_REQ),
    .MEM_WE     (MEM_WE),
    .MEM_ADDR   (MEM_ADDR),
    .MEM_WDATA  (MEM_WDATA),
    .MEM_GNT    (MEM_GNT),
    .MEM_RVALID (MEM_RVALID),
    .MEM_RDATA  (MEM_RDATA)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [127:0] s, input logic [127:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // entered just after a falling edge; polls only settled values
  task automatic wt(input int k);
    for (int i = 0; i < 200; i++) begin
      #1;
      if ((k == 0 && RX_READY === 1'b1) || (k == 1 && TX_REQ_READY === 1'b1)
          || (k == 2 && TX_DONE === 1'b1)) return;
      @(negedge MCLK);
    end
    n_mismatch++;
    final_report();
  endtask

  function automatic logic [14:0] ma(input int w);
    logic [15:0] a;
    a = BASE_ADDR + {7'h00, RX_BUFFER, 4'h0} + 16'(2 * w);
    return a[15:1];
  endfunction

  function automatic logic [15:0] rd(input int w);
    return cmbf_mem_model_inst.mem[ma(w)];
  endfunction

  function automatic logic [15:0] ew(input int w);
    logic x, r;
    x = RX_EXTENDED;
    r = RX_REMOTE;
    case (w)
      0: ew = {3'h0, RX_STD_IDENT, x | r, x};
      1: ew = {4'h0, RX_EXT_IDENT[17:6]};
      2: ew = {RX_EXT_IDENT[5:0], x & r, 5'h00, RX_DLC};
      7: ew = {3'h0, RX_FILTER, 8'h00};
      default: ew = RX_DATA[16*(w-3) +: 16];
    endcase
  endfunction

  // store a message, check the eight words, fetch it back
  task automatic run(input logic [4:0] b, input logic [10:0] s,
                     input logic [17:0] e, input logic x, input logic r,
                     input logic [3:0] d, input logic [63:0] p,
                     input logic [4:0] f, input logic sl);
    @(negedge MCLK);
    SLOW = sl;
    RX_BUFFER = b;
    TX_BUFFER = b;
    RX_STD_IDENT = s;
    RX_EXT_IDENT = e;
    RX_EXTENDED = x;
    RX_REMOTE = r;
    RX_DLC = d;
    RX_DATA = p;
    RX_FILTER = f;
    RX_VALID = 1'b1;
    wt(0);
    @(negedge MCLK);
    RX_VALID = 1'b0;
    wt(1);
    check(rd(0), ew(0));
    check(rd(1), ew(1));
    check(rd(2), ew(2));
    for (int w = 3; w < 7; w++) begin
      check(rd(w), ew(w));
    end
    check(rd(7), ew(7));
    // software sets the extended remote flag on a standard frame
    if (!x) cmbf_mem_model_inst.mem[ma(2)][9] = 1'b1;
    @(negedge MCLK);
    TX_REQ = 1'b1;
    wt(1);
    @(negedge MCLK);
    TX_REQ = 1'b0;
    wt(2);
    check(TX_STD_IDENT, s);
    check(TX_EXT_IDENT, e);
    check(TX_EXTENDED, x);
    check(TX_REMOTE, r);
    check(TX_DLC, d);
    check(TX_DATA, p);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(negedge MCLK);
    RST = 1'b0;
    // reserved bits of word 2 are never set by the stimulus
    run(5'h00, 11'h7FF, 18'h2AAAA, 1'b0, 1'b0, 4'h8,
        64'h0706050403020100, 5'h1F, 1'b0);
    run(5'h1F, 11'h001, 18'h3FFFF, 1'b1, 1'b1, 4'hF,
        64'hFEDCBA9876543210, 5'h00, 1'b1);
    run(5'h05, 11'h555, 18'h15555, 1'b0, 1'b1, 4'h0,
        64'h00FF00FF5AA5C33C, 5'h0A, 1'b1);
    run(5'h0A, 11'h2AA, 18'h0F0F0, 1'b1, 1'b0, 4'h1,
        64'h8000000000000001, 5'h15, 1'b0);
    final_report();
  end
endmodule // tb_top
